// File: rtl/temp_alert_pkg.sv
package temp_alert_pkg;

    // ==========================================================
    // Widths, bus codes and address layout.
    localparam int           TEMP_W          = 12;
    localparam logic [7:0]   ALERT_RESP_BYTE = 8'h19;
    localparam logic [7:0]   GC_LATCH_CMD    = 8'h04;
    localparam logic [7:0]   GC_RESET_CMD    = 8'h06;
    localparam logic [6:0]   GC_ADDRESS      = 7'h00;
    localparam logic [4:0]   HS_CODE_PREFIX  = 5'h01;
    localparam logic [3:0]   ADDR_BASE       = 4'h9;
    localparam logic [6:0]   ADDR_RESET      = 7'h48;

    // ==========================================================
    // Input filter timing.
    localparam int           CLK_PERIOD_NS   = 50;
    localparam int           SPIKE_FAST_NS   = 100;
    localparam int           SPIKE_HS_NS     = 10;
    localparam int           FILT_FAST_INT   = (SPIKE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int           FILT_HS_INT     = (SPIKE_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]   FILT_FAST_CYC   = (FILT_FAST_INT < 1) ? 2'h1 : 2'(FILT_FAST_INT);
    localparam logic [1:0]   FILT_HS_CYC     = (FILT_HS_INT < 1) ? 2'h1 : 2'(FILT_HS_INT);

    // ==========================================================
    // Reset values and last bit index.
    localparam logic [2:0]   FAULT_CNT_RESET = 3'h0;
    localparam logic [7:0]   BYTE_RESET      = 8'h00;
    localparam logic [2:0]   BITS_LAST       = 3'h7;

    // ==========================================================
    // Carriers and states.
    typedef struct packed {
        logic powerDownBit;
        logic thermostatModeSelect;
        logic alertSenseInvert;
        logic faultCountSelectHi;
        logic faultCountSelectLo;
    } thermo_cfg_type;

    typedef struct packed {
        logic [TEMP_W-1:0] upperLimit;
        logic [TEMP_W-1:0] lowerLimit;
    } limits_type;

    typedef enum logic [2:0] {
        IDLE_ST,
        ADDR_ST,
        ACK_ST,
        DATA_ST,
        TX_ST,
        MACK_ST,
        SKIP_ST
    } slave_state_type;

    function automatic logic [2:0] faultNeed(input logic hi, input logic lo);
        case ({hi, lo})
            2'h0:    faultNeed = 3'h1;
            2'h1:    faultNeed = 3'h2;
            2'h2:    faultNeed = 3'h4;
            default: faultNeed = 3'h6;
        endcase
    endfunction

endpackage

// File: rtl/temp_sensor_i2c_alert_slave.sv
`timescale 1ns/10ps
// What this block does
// RL1: In interrupt mode, acknowledge alert-response byte and return own address.
// RL2: Returned address LSB is 0 for upper cause, 1 for lower, inverted by invert.
// RL3: Winning arbitration clears the alert afterwards; losing keeps it asserted.
// RL4: Without an alert pin, answer alert response too; master must poll.
// RL5: Acknowledge general call address with write bit; next byte is a command.
// RL6: General call 04h re-latches address pins, no register reset.
// RL7: General call 06h re-latches address pins and resets all registers.
// RL8: Hs master code is not acknowledged but switches filters to high speed.
// RL9: High-speed filtering stays until STOP, then fast-mode filtering returns.
// RL10: Master starts each transfer with START; both lines high means idle.
// RL11: Master ends each transfer with repeated START or STOP.
// RL12: Byte count is unlimited; the receiver acknowledges every byte.
// RL13: Addressed receiver holds SDA low through the ninth clock high phase.
// RL14: Master ends a read by not acknowledging the last byte.
// RL15: Shutdown finishes the running conversion, then stops; serial side stays alive.
// RL16: With shutdown clear, conversions run back to back continuously.
// RL17: One-shot write during shutdown starts exactly one conversion.
// RL18: Status bit reads 1 until upper fault count, 0 until lower; invertible.
// RL19: Thermostat mode 0 gives comparator alert, 1 gives interrupt alert.
// RL20: Comparator alert is active from upper limit until below lower limit.
// RL21: Interrupt alert sets on limit crossing, clears on temperature read.
// RL22: Faults count only consecutively; 1, 2, 4 or 6 selected; breaks reset.
// RL23: Alert is active low with invert clear, active high with it set.
// RL24: Limit comparisons are signed at full 12-bit width.
// RL25: Ignore other slaves' traffic; release SDA unless acknowledging or sending.
module temp_sensor_i2c_alert_slave
    import temp_alert_pkg::*;
(
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Serial bus pins.
    input  wire logic              sclIn,
    input  wire logic              sdaIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    // Address select pins.
    input  wire logic              addressSelectPinA,
    input  wire logic              addressSelectPinB,
    output logic [6:0]             slaveAddress,
    // Configuration and register events.
    input  wire thermo_cfg_type    cfg,
    input  wire limits_type        limits,
    input  wire logic              oneShotWrite,
    input  wire logic              tempRegRead,
    // Converter handshake.
    output logic                   convStart,
    input  wire logic              convDone,
    input  wire logic [TEMP_W-1:0] convValue,
    // Status.
    output logic                   singleConversionStatusBit,
    output logic                   alertPin,
    output logic                   hsMode,
    output logic                   gcRegReset,
    // Register data path.
    output logic                   rxValid,
    output logic [7:0]             rxData,
    input  wire logic [7:0]        txData,
    output logic                   txTaken
);

    // ==========================================================
    // Pin synchronisers and spike filters.
    logic [1:0] meta;
    logic [1:0] synced;
    logic [1:0] line;
    logic [1:0] stableCnt [2];
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic       sclPrev;
    logic       sdaPrev;
    wire  [1:0] filtLen = hsMode ? FILT_HS_CYC : FILT_FAST_CYC; // [RL8] [RL9]

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta      <= 2'h3;
            synced    <= 2'h3;
            line      <= 2'h3;
            stableCnt <= '{2'h0, 2'h0};
            sclPrev   <= 1'b1;
            sdaPrev   <= 1'b1;
        end
        else
        begin
            meta    <= {sdaIn, sclIn};
            synced  <= meta;
            sclPrev <= line[0];
            sdaPrev <= line[1];
            for (int i = 0; i < 2; i++)
            begin
                if (synced[i] == line[i])
                    stableCnt[i] <= 2'h0;
                else if (stableCnt[i] + 2'h1 >= filtLen)
                begin
                    line[i]      <= synced[i];
                    stableCnt[i] <= 2'h0;
                end
                else
                    stableCnt[i] <= stableCnt[i] + 2'h1;
            end
        end
    end

    // Strap pins run free through reset, so the first latch sees their real level.
    always_ff @(posedge sys_clk)
    begin
        pinMeta <= {addressSelectPinB, addressSelectPinA};
        pinSync <= pinMeta;
    end

    wire sclLine   = line[0];
    wire sdaLine   = line[1];
    wire sclRise   = sclLine && !sclPrev;
    wire sclFall   = !sclLine && sclPrev;
    wire startCond = sclLine && sclPrev && sdaPrev && !sdaLine; // [RL10]
    wire stopCond  = sclLine && sclPrev && !sdaPrev && sdaLine; // [RL11]

    // ==========================================================
    // Thermostat, fault queue and alert.
    logic [2:0] faultCnt;
    logic       compState;
    logic       intPending;
    logic       causeLow;
    logic       alertWin;

    wire signed [TEMP_W-1:0] tempS  = convValue;
    wire signed [TEMP_W-1:0] upperS = limits.upperLimit;
    wire signed [TEMP_W-1:0] lowerS = limits.lowerLimit;
    wire        hiFault  = tempS >= upperS; // [RL24]
    wire        loFault  = tempS < lowerS; // [RL24]
    wire        qualify  = compState ? loFault : hiFault;
    wire  [2:0] need     = faultNeed(cfg.faultCountSelectHi, cfg.faultCountSelectLo);
    wire  [2:0] nextCnt  = faultCnt + 3'h1;
    wire        trip     = convDone && qualify && (nextCnt >= need); // [RL22]
    wire        intClear = tempRegRead || alertWin || gcRegReset;
    wire        alertAct = cfg.thermostatModeSelect ? intPending : compState; // [RL19]

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            faultCnt   <= FAULT_CNT_RESET;
            compState  <= 1'b0;
            intPending <= 1'b0;
            causeLow   <= 1'b0;
        end
        else
        begin
            if (gcRegReset)
            begin
                faultCnt  <= FAULT_CNT_RESET; // [RL7]
                compState <= 1'b0;
            end
            else if (trip)
            begin
                compState <= !compState; // [RL20]
                faultCnt  <= FAULT_CNT_RESET;
            end
            else if (convDone)
                faultCnt <= qualify ? nextCnt : FAULT_CNT_RESET; // [RL22]
            if (trip && !gcRegReset)
            begin
                intPending <= 1'b1; // [RL21]
                causeLow   <= compState;
            end
            else if (intClear)
                intPending <= 1'b0; // [RL21]
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            alertPin                  <= 1'b1;
            singleConversionStatusBit <= 1'b1;
        end
        else
        begin
            alertPin                  <= cfg.alertSenseInvert ? alertAct : !alertAct; // [RL23]
            singleConversionStatusBit <= cfg.alertSenseInvert ? compState : !compState; // [RL18]
        end
    end

    // ==========================================================
    // Conversion sequencing.
    logic convBusy;
    logic oneShotPend;
    wire  startNow = !convBusy && (!cfg.powerDownBit || oneShotPend); // [RL15] [RL16]

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            convBusy    <= 1'b0;
            oneShotPend <= 1'b0;
            convStart   <= 1'b0;
        end
        else
        begin
            convStart <= startNow;
            if (startNow)
                convBusy <= 1'b1;
            else if (convDone)
                convBusy <= 1'b0;
            if (oneShotWrite && cfg.powerDownBit)
                oneShotPend <= 1'b1; // [RL17]
            else if (startNow || gcRegReset)
                oneShotPend <= 1'b0;
        end
    end

    // ==========================================================
    // Address latch after reset release and on general call.
    logic latchPending;
    logic gcLatch;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            latchPending <= 1'b1;
            slaveAddress <= ADDR_RESET;
        end
        else
        begin
            latchPending <= 1'b0;
            if (latchPending || gcLatch)
                slaveAddress <= {ADDR_BASE, pinSync[1], pinSync[0], 1'b0}; // [RL6] [RL7]
        end
    end

    // ==========================================================
    // Bus slave state machine.
    slave_state_type state;
    logic [7:0]      shiftReg;
    logic [7:0]      txShift;
    logic [2:0]      bitCnt;
    logic            byteFull;
    logic            gcCmd;
    logic            alertTx;
    logic            readAfter;

    wire gcHit  = shiftReg[7:1] == GC_ADDRESS && !shiftReg[0]; // [RL5]
    wire araHit = shiftReg == ALERT_RESP_BYTE && cfg.thermostatModeSelect && intPending; // [RL1] [RL4]
    wire hsHit  = shiftReg[7:3] == HS_CODE_PREFIX; // [RL8]
    wire ownHit = shiftReg[7:1] == slaveAddress;
    wire araBit = causeLow ^ cfg.alertSenseInvert; // [RL2]
    wire lostArb = sclRise && txShift[7] && !sdaLine; // [RL3]

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= IDLE_ST;
            shiftReg <= BYTE_RESET;
            txShift <= BYTE_RESET;
            bitCnt <= 3'h0;
            byteFull <= 1'b0;
            gcCmd <= 1'b0;
            alertTx <= 1'b0;
            readAfter <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            hsMode <= 1'b0;
            alertWin <= 1'b0;
            gcLatch <= 1'b0;
            gcRegReset <= 1'b0;
            rxValid <= 1'b0;
            rxData <= BYTE_RESET;
            txTaken <= 1'b0;
        end
        else
        begin
            alertWin <= 1'b0;
            gcLatch <= 1'b0;
            gcRegReset <= 1'b0;
            rxValid <= 1'b0;
            txTaken <= 1'b0;
            if (stopCond)
            begin
                state <= IDLE_ST;
                sdaOe <= 1'b0;
                hsMode <= 1'b0; // [RL9]
            end
            else if (startCond)
            begin
                state <= ADDR_ST;
                sdaOe <= 1'b0;
                bitCnt <= 3'h0;
                byteFull <= 1'b0;
                gcCmd <= 1'b0;
                alertTx <= 1'b0;
                readAfter <= 1'b0;
            end
            else
            begin
                case (state)
                    ADDR_ST, DATA_ST:
                    begin
                        if (sclRise && !byteFull)
                        begin
                            shiftReg <= {shiftReg[6:0], sdaLine};
                            bitCnt <= bitCnt + 3'h1;
                            byteFull <= bitCnt == BITS_LAST;
                        end
                        else if (sclFall && byteFull)
                        begin
                            byteFull <= 1'b0;
                            bitCnt <= 3'h0;
                            if (state == DATA_ST)
                            begin
                                state <= ACK_ST;
                                sdaOe <= 1'b1; // [RL12] [RL13]
                                rxValid <= !gcCmd;
                                rxData <= shiftReg;
                                gcCmd <= 1'b0;
                                gcLatch <= gcCmd && (shiftReg == GC_LATCH_CMD
                                                     || shiftReg == GC_RESET_CMD); // [RL6]
                                gcRegReset <= gcCmd && shiftReg == GC_RESET_CMD; // [RL7]
                            end
                            else if (hsHit)
                            begin
                                state <= SKIP_ST; // [RL8]
                                hsMode <= 1'b1;
                            end
                            else if (gcHit || araHit || ownHit)
                            begin
                                state <= ACK_ST;
                                sdaOe <= 1'b1; // [RL13]
                                gcCmd <= gcHit; // [RL5]
                                alertTx <= araHit && !gcHit;
                                readAfter <= shiftReg[0] && !gcHit;
                            end
                            else
                                state <= SKIP_ST; // [RL25]
                        end
                    end
                    ACK_ST:
                        if (sclFall)
                        begin
                            if (readAfter)
                            begin
                                state <= TX_ST;
                                txShift <= alertTx ? {slaveAddress, araBit} : txData; // [RL1] [RL2]
                                sdaOe <= alertTx ? !slaveAddress[6] : !txData[7];
                                txTaken <= !alertTx;
                                readAfter <= 1'b0;
                            end
                            else
                            begin
                                state <= DATA_ST;
                                sdaOe <= 1'b0; // [RL25]
                            end
                        end
                    TX_ST:
                        if (lostArb)
                        begin
                            state <= SKIP_ST; // [RL3]
                            sdaOe <= 1'b0;
                            alertTx <= 1'b0;
                        end
                        else if (sclFall)
                        begin
                            bitCnt <= bitCnt + 3'h1;
                            txShift <= {txShift[6:0], 1'b0};
                            sdaOe <= (bitCnt == BITS_LAST) ? 1'b0 : !txShift[6];
                            if (bitCnt == BITS_LAST)
                                state <= MACK_ST;
                        end
                    MACK_ST:
                        if (sclRise)
                        begin
                            alertWin <= alertTx; // [RL3]
                            alertTx <= 1'b0;
                            readAfter <= !alertTx && !sdaLine; // [RL14]
                            state <= (!alertTx && !sdaLine) ? ACK_ST : SKIP_ST;
                        end
                    default:
                        sdaOe <= 1'b0; // [RL25]
                endcase
            end
        end
    end

    // ==========================================================
    // Checks.
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_ack_low;
        (state == ACK_ST && !readAfter && sclRise) |-> sdaOe;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack not driven low"); // [RL13]

    property p_hs_exit;
        stopCond |=> !hsMode && state == IDLE_ST;
    endproperty
    a_hs_exit: assert property (p_hs_exit) else $error("hs mode kept after stop"); // [RL9]

    property p_hs_enter;
        (state == ADDR_ST && byteFull && sclFall && hsHit && !startCond && !stopCond)
            |=> hsMode && !sdaOe;
    endproperty
    a_hs_enter: assert property (p_hs_enter) else $error("hs code mishandled"); // [RL8]

    property p_alert_pol;
        1 |=> alertPin == ($past(cfg.alertSenseInvert) ? $past(alertAct) : !$past(alertAct));
    endproperty
    a_alert_pol: assert property (p_alert_pol) else $error("alert polarity wrong"); // [RL23]

    property p_comp_on_conv;
        $changed(compState) |-> $past(convDone) || $past(gcRegReset);
    endproperty
    a_comp_on_conv: assert property (p_comp_on_conv) else $error("state moved w/o conv"); // [RL22]

    property p_continuous;
        (!convBusy && !cfg.powerDownBit) |=> convStart ##1 convBusy;
    endproperty
    a_continuous: assert property (p_continuous) else $error("no continuous start"); // [RL16]

    property p_shutdown;
        (cfg.powerDownBit && !oneShotPend && !convBusy) |=> !convStart;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("conversion in shutdown"); // [RL15]

    property p_read_clear;
        (tempRegRead && !trip) |=> !intPending;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear"); // [RL21]

    property p_lose_keep;
        (state == TX_ST && lostArb && alertTx && !intClear) |=> intPending && state == SKIP_ST;
    endproperty
    a_lose_keep: assert property (p_lose_keep) else $error("lost but alert cleared"); // [RL3]

    property p_skip_release;
        state == SKIP_ST |-> !sdaOe;
    endproperty
    a_skip_release: assert property (p_skip_release) else $error("sda held while idle"); // [RL25]

endmodule

// File: test/i2c_master_model.sv
`timescale 1ns/10ps
// ============================================================
// Bus master that makes SCL and pulls SDA low through an open drain.
module i2c_master_model
(
    // Clock and bus lines.
    input  wire logic sys_clk,
    input  wire logic sdaWire,
    output logic      sclOut,
    output logic      sdaPull
);
    initial
    begin
        sclOut  = 1'h1;
        sdaPull = 1'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Start from idle or as a repeated start from SCL low.
    task automatic startCond();
        hold(1);
        sdaPull <= 1'h0;
        hold(5);
        sclOut <= 1'h1;
        hold(10);
        sdaPull <= 1'h1;
        hold(10);
        sclOut <= 1'h0;
        hold(3);
    endtask
    // Stop releases SDA while SCL is high.
    task automatic stopCond();
        hold(1);
        sdaPull <= 1'h1;
        hold(7);
        sclOut <= 1'h1;
        hold(10);
        sdaPull <= 1'h0;
        hold(10);
    endtask
    // Nine clocks, MSB first; bit 0 is the acknowledge clock.
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            sdaPull <= !d[i];
            hold(7);
            sclOut <= 1'h1;
            hold(5);
            r[i] = sdaWire;
            hold(5);
            sclOut <= 1'h0;
            hold(3);
        end
    endtask
endmodule

// File: test/testbench.sv
`timescale 1ns/10ps
// ============================================================
// Self-checking bench with a converter stub and mode scenarios.
module testbench;
    import temp_alert_pkg::*;
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin failCount++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
    logic              sys_clk = 1'h0;
    logic              rst = 1'h1;
    logic              addressSelectPinA = 1'h1;
    logic              addressSelectPinB = 1'h0;
    thermo_cfg_type    cfg = '0;
    limits_type        limits = {12'h190, 12'h0C8};
    logic              oneShotWrite = 1'h0;
    logic              tempRegRead = 1'h0;
    logic              convDone = 1'h0;
    logic [TEMP_W-1:0] convValue = '0;
    logic [TEMP_W-1:0] tempNow = 12'hE70;
    logic              convStart, singleConversionStatusBit, alertPin, hsMode, gcRegReset;
    logic              sdaOe, sclOut, sdaPull, sdaOut, rxValid, txTaken;
    logic [7:0]        rxData;
    logic [7:0]        rxLast = 8'h00;
    logic [6:0]        slaveAddress;
    logic [8:0]        r;
    logic [9:0]        rows [6] = '{{8'h94, 2'h0}, {8'hA0, 2'h2}, {8'h00, 2'h0},
                                    {8'h01, 2'h2}, {8'h19, 2'h2}, {8'h0B, 2'h3}};
    int                failCount = 0;
    int                nChecks = 0;
    int                nStart = 0;
    int                nGc = 0;
    int                nTx = 0;
    int                s0;
    wire               sdaWire = !((sdaOe && !sdaOut) || sdaPull);
    always #25 sys_clk = ~sys_clk;
    temp_sensor_i2c_alert_slave temp_sensor_i2c_alert_slave_i (.sys_clk(sys_clk), .rst(rst),
        .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addressSelectPinA(addressSelectPinA), .addressSelectPinB(addressSelectPinB),
        .slaveAddress(slaveAddress), .cfg(cfg), .limits(limits), .oneShotWrite(oneShotWrite),
        .tempRegRead(tempRegRead), .convStart(convStart), .convDone(convDone),
        .convValue(convValue), .singleConversionStatusBit(singleConversionStatusBit),
        .alertPin(alertPin), .hsMode(hsMode), .gcRegReset(gcRegReset), .rxValid(rxValid),
        .rxData(rxData), .txData(8'hA5), .txTaken(txTaken));
    i2c_master_model i2c_master_model_i (.sys_clk(sys_clk), .sdaWire(sdaWire),
        .sclOut(sclOut), .sdaPull(sdaPull));
    // ============================================================
    // Converter stub answers one cycle after each start.
    always @(posedge sys_clk)
    begin
        convDone  <= convStart;
        convValue <= tempNow;
        nStart    <= nStart + convStart;
        nGc       <= nGc + gcRegReset;
        nTx       <= nTx + txTaken;
        if (rxValid)
            rxLast <= rxData;
    end
    task automatic setT(input logic [TEMP_W-1:0] v, input int n);
        @(posedge sys_clk) tempNow <= v;
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pulse(input logic rd);
        @(posedge sys_clk) {tempRegRead, oneShotWrite} <= {rd, !rd};
        @(posedge sys_clk) {tempRegRead, oneShotWrite} <= 2'h0;
        repeat (15) @(negedge sys_clk);
    endtask
    task automatic ara(input logic [8:0] d);
        i2c_master_model_i.startCond();
        i2c_master_model_i.xfer({ALERT_RESP_BYTE, 1'h1}, r);
        `CHK(r[0], 1'h0)
        i2c_master_model_i.xfer(d, r);
        i2c_master_model_i.stopCond();
    endtask
    task automatic gcCmd(input logic [7:0] cmd);
        i2c_master_model_i.startCond();
        i2c_master_model_i.xfer({GC_ADDRESS, 2'h1}, r);
        `CHK(r[0], 1'h0)
        i2c_master_model_i.xfer({cmd, 1'h1}, r);
        `CHK(r[0], 1'h0)
        i2c_master_model_i.stopCond();
        repeat (5) @(negedge sys_clk);
    endtask
    task automatic summarize();
        if (failCount == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ============================================================
    // Main sequence.
    initial
    begin
        repeat (3) @(negedge sys_clk);
        `CHK(slaveAddress, ADDR_RESET)
        `CHK(alertPin, 1'h1)
        `CHK(singleConversionStatusBit, 1'h1)
        `CHK(sdaOe, 1'h0)
        @(posedge sys_clk) rst <= 1'h0;
        repeat (30) @(negedge sys_clk);
        `CHK(slaveAddress, 7'h4A)
        for (int i = 0; i < 6; i++)
        begin
            i2c_master_model_i.startCond();
            i2c_master_model_i.xfer({rows[i][9:2], 1'h1}, r);
            `CHK(r[0], rows[i][1])
            `CHK(hsMode, rows[i][0])
            i2c_master_model_i.stopCond();
            `CHK(hsMode, 1'h0)
            `CHK(sdaOe, 1'h0)
        end
        // Own write of one byte, then an own read acked once and refused once.
        i2c_master_model_i.startCond();
        i2c_master_model_i.xfer({8'h94, 1'h1}, r);
        i2c_master_model_i.xfer({8'hC3, 1'h1}, r);
        `CHK(r[0], 1'h0)
        i2c_master_model_i.startCond();
        i2c_master_model_i.xfer({8'h95, 1'h1}, r);
        i2c_master_model_i.xfer({8'hFF, 1'h0}, r);
        `CHK(r[8:1], 8'hA5)
        i2c_master_model_i.xfer({8'hFF, 1'h1}, r);
        i2c_master_model_i.stopCond();
        `CHK(rxLast, 8'hC3)
        `CHK(nTx, 2)
        setT(12'h190, 20);
        `CHK(alertPin, 1'h0)
        `CHK(singleConversionStatusBit, 1'h0)
        setT(12'h100, 20);
        `CHK(alertPin, 1'h0)
        setT(12'hE70, 20);
        `CHK(alertPin, 1'h1)
        `CHK(singleConversionStatusBit, 1'h1)
        @(posedge sys_clk) cfg <= 5'h04;
        repeat (5) @(negedge sys_clk);
        `CHK(alertPin, 1'h0)
        `CHK(singleConversionStatusBit, 1'h0)
        // Shutdown with a queue of six faults; single conversions on demand.
        @(posedge sys_clk) cfg <= 5'h13;
        repeat (20) @(negedge sys_clk);
        s0 = nStart;
        repeat (30) @(negedge sys_clk);
        `CHK(nStart, s0)
        for (int i = 0; i < 10; i++)
        begin
            setT((i == 3) ? 12'h100 : 12'h190, 1);
            pulse(1'h0);
            `CHK(nStart, s0 + i + 1)
            `CHK(alertPin, (i == 9) ? 1'h0 : 1'h1)
        end
        // Interrupt mode: low crossing, lost then won alert response.
        @(posedge sys_clk) cfg <= 5'h08;
        setT(12'hE70, 30);
        `CHK(alertPin, 1'h0)
        ara({8'h7F, 1'h1});
        `CHK(alertPin, 1'h0)
        ara({8'hFF, 1'h1});
        `CHK(r[8:1], {7'h4A, 1'h1})
        `CHK(alertPin, 1'h1)
        setT(12'h190, 30);
        `CHK(alertPin, 1'h0)
        pulse(1'h1);
        `CHK(alertPin, 1'h1)
        gcCmd(GC_RESET_CMD);
        `CHK(nGc, 1)
        @(posedge sys_clk) addressSelectPinB <= 1'h1;
        gcCmd(GC_LATCH_CMD);
        `CHK(slaveAddress, 7'h4E)
        `CHK(nGc, 1)
        summarize();
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        failCount++;
        summarize();
    end
endmodule
